// file: common/rtc_ctrl_pkg.sv
// constants for the control-register block of the serial real-time clock
// assumes a 20 MHz system clock and a 32.768 kHz oscillator level on a pin
package rtc_ctrl_pkg;
    // register addresses on the internal register port
    localparam logic [3:0] ADDR_SECONDS = 4'h0;
    localparam logic [3:0] ADDR_OSC_ADJUST = 4'h7;
    localparam logic [3:0] ADDR_CTRL1 = 4'hE;
    localparam logic [3:0] ADDR_CTRL2 = 4'hF;
    // alarm_mode_interrupt_control field positions
    localparam int C1_WEEKLY_EN = 7;
    localparam int C1_DAILY_EN = 6;
    localparam int C1_HOUR24 = 5;
    localparam int C1_CLK_DIS_B = 4;
    localparam int C1_TEST = 3;
    localparam int C1_SEL_HI = 2;
    // status_and_output_control field positions
    localparam int C2_VTHRESH = 7;
    localparam int C2_LOW_VOLT = 6;
    localparam int C2_OSC_RUN = 5;
    localparam int C2_POWER_UP = 4;
    localparam int C2_CLK_DIS_A = 3;
    localparam int C2_PERIODIC = 2;
    localparam int C2_WEEKLY = 1;
    localparam int C2_DAILY = 0;
    // oscillation adjustment: sign bit and magnitude width
    localparam int ADJ_SIGN = 6;
    localparam int ADJ_MAG_W = 6;
    // reset values
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [6:0] ADJUST_RESET = 7'h00;
    // periodic interrupt selections
    typedef enum logic [2:0] {
        PER_OFF = 3'h0, PER_LOW = 3'h1, PER_2HZ = 3'h2, PER_1HZ = 3'h3,
        PER_SEC = 3'h4, PER_MIN = 3'h5, PER_HOUR = 3'h6, PER_MONTH = 3'h7
    } periodic_type;
    // sub-second divider of oscillator edges
    localparam int DIV_W = 15;
    localparam int DIV_1HZ_BIT = 14;
    localparam int DIV_2HZ_BIT = 13;
    localparam logic [DIV_W-1:0] DIV_ZERO = 15'h0000;
    // adjustment shift per step in oscillator counts, period in seconds
    localparam int ADJ_STEP_COUNTS = 2;
    localparam logic [5:0] ADJ_PERIOD_LAST = 6'h3B;
    // seconds increment follows the pulse falling edge
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int TICK_DELAY_US = 92;
    localparam int TICK_DELAY_CYCLES = (TICK_DELAY_US * 1000) / CLOCK_PERIOD_NS;
    localparam int DELAY_W = 11;
    // bcd hour constants
    localparam logic [5:0] HOUR_PM = 6'h20;
    localparam logic [5:0] HOUR_AM12 = 6'h12;
    localparam logic [5:0] HOUR_AM11 = 6'h11;
    localparam logic [5:0] HOUR_AM1 = 6'h01;
    localparam logic [5:0] HOUR_PM12 = 6'h32;
    localparam logic [5:0] HOUR_PM11 = 6'h31;
    localparam logic [5:0] HOUR_PM1 = 6'h21;
    localparam logic [5:0] HOUR_23 = 6'h23;
    localparam logic [5:0] HOUR_00 = 6'h00;
endpackage

// file: rtl/rtc_control.sv
// control registers, periodic interrupt, alarm gating and 32 kHz output gate
// assumes a register port driven by the serial front end and outside counters
`timescale 1ns/1ps
module rtc_control (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [3:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWriteData,
    output logic [7:0] regReadData,
    input wire logic oscPin,
    input wire logic lowSupplyPin,
    input wire logic oscHalted,
    input wire logic weeklyMatch,
    input wire logic dailyMatch,
    input wire logic minuteCarry,
    input wire logic hourCarry,
    input wire logic monthCarry,
    input wire logic [5:0] hourNow,
    output logic [5:0] hourNext,
    output logic secondTick,
    output logic hour24Mode,
    output logic weeklyAlarmEnable,
    output logic dailyAlarmEnable,
    output logic testMode,
    output logic voltageThresholdSelect,
    output logic supplyMonitorEnable,
    output logic interrupt_out_n,
    output logic clk32_out
);
    // next bcd value of one hour byte
    function automatic logic [5:0] bcdInc(input logic [5:0] h);
        if (h[3:0] == 4'h9) begin
            bcdInc = {h[5:4] + 2'h1, 4'h0};
        end else begin
            bcdInc = {h[5:4], h[3:0] + 4'h1};
        end
    endfunction

    // hour after the given one in the chosen format
    function automatic logic [5:0] hourAfter(input logic [5:0] h, input logic mode24);
        if (mode24) begin
            hourAfter = (h == rtc_ctrl_pkg::HOUR_23) ? rtc_ctrl_pkg::HOUR_00 : bcdInc(h);
        end else if (h == rtc_ctrl_pkg::HOUR_AM12) begin
            hourAfter = rtc_ctrl_pkg::HOUR_AM1;
        end else if (h == rtc_ctrl_pkg::HOUR_AM11) begin
            hourAfter = rtc_ctrl_pkg::HOUR_PM12;
        end else if (h == rtc_ctrl_pkg::HOUR_PM12) begin
            hourAfter = rtc_ctrl_pkg::HOUR_PM1;
        end else if (h == rtc_ctrl_pkg::HOUR_PM11) begin
            hourAfter = rtc_ctrl_pkg::HOUR_AM12;
        end else begin
            hourAfter = (h & rtc_ctrl_pkg::HOUR_PM) | bcdInc(h & ~rtc_ctrl_pkg::HOUR_PM);
        end
    endfunction

    logic [7:0] ctrl1_reg; // alarm_mode_interrupt_control
    logic [6:0] adjust_reg; // oscillation adjustment value
    logic vthresh_reg, lowVolt_reg, oscRun_reg, powerUp_reg, clkDisA_reg;
    logic periodic_reg, weekly_reg, daily_reg; // event flags
    logic osc1_reg, osc2_reg, osc3_reg, oscLevel_reg; // oscillator synchroniser
    logic low1_reg, low2_reg, low3_reg, lowLevel_reg; // supply monitor synchroniser
    logic [rtc_ctrl_pkg::DIV_W-1:0] div_reg; // sub-second divider
    logic [5:0] secCount_reg; // seconds since last adjustment
    logic [rtc_ctrl_pkg::DELAY_W-1:0] delay_reg; // falling edge to increment
    logic delayRun_reg;
    logic [7:0] ctrl2Value;
    logic oscRise, wrCtrl1, wrCtrl2, wrAdjust, wrSeconds, divWrap, levelEvent;
    logic pulseMode, levelMode, pulseLow, periodicLow;
    rtc_ctrl_pkg::periodic_type periodicSel;

    assign wrCtrl1 = regWrite && regAddr == rtc_ctrl_pkg::ADDR_CTRL1;
    assign wrCtrl2 = regWrite && regAddr == rtc_ctrl_pkg::ADDR_CTRL2;
    assign wrAdjust = regWrite && regAddr == rtc_ctrl_pkg::ADDR_OSC_ADJUST;
    assign wrSeconds = regWrite && regAddr == rtc_ctrl_pkg::ADDR_SECONDS;
    assign periodicSel = rtc_ctrl_pkg::periodic_type'(ctrl1_reg[rtc_ctrl_pkg::C1_SEL_HI:0]);
    assign pulseMode = periodicSel == rtc_ctrl_pkg::PER_2HZ || periodicSel == rtc_ctrl_pkg::PER_1HZ;
    assign levelMode = ctrl1_reg[rtc_ctrl_pkg::C1_SEL_HI];
    // a rise counts once second and third stages agree
    assign oscRise = osc2_reg && osc3_reg && !oscLevel_reg;
    assign divWrap = oscRise && (&div_reg);
    // pulse output is low in the first half of each period
    assign pulseLow = (periodicSel == rtc_ctrl_pkg::PER_1HZ) ? !div_reg[rtc_ctrl_pkg::DIV_1HZ_BIT]
                                                             : !div_reg[rtc_ctrl_pkg::DIV_2HZ_BIT];
    // level events by selection
    always_comb begin
        unique case (periodicSel)
            rtc_ctrl_pkg::PER_SEC: levelEvent = 1'b1;
            rtc_ctrl_pkg::PER_MIN: levelEvent = minuteCarry;
            rtc_ctrl_pkg::PER_HOUR: levelEvent = hourCarry;
            rtc_ctrl_pkg::PER_MONTH: levelEvent = monthCarry;
            default: levelEvent = 1'b0;
        endcase
    end
    assign periodicLow = (periodicSel == rtc_ctrl_pkg::PER_LOW) || (pulseMode && pulseLow)
                       || (levelMode && periodic_reg);

    // three-stage synchronisers for pin inputs
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            {osc1_reg, osc2_reg, osc3_reg, oscLevel_reg} <= 4'h0;
            {low1_reg, low2_reg, low3_reg, lowLevel_reg} <= 4'h0;
        end else begin
            {osc1_reg, osc2_reg, osc3_reg} <= {oscPin, osc1_reg, osc2_reg};
            {low1_reg, low2_reg, low3_reg} <= {lowSupplyPin, low1_reg, low2_reg};
            if (osc2_reg == osc3_reg) begin
                oscLevel_reg <= osc3_reg;
            end
            if (low2_reg == low3_reg) begin
                lowLevel_reg <= low3_reg;
            end
        end
    end

    // sub-second divider with seconds write and adjustment preload
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            div_reg <= rtc_ctrl_pkg::DIV_ZERO;
            secCount_reg <= 6'h00;
        end else if (wrSeconds) begin
            div_reg <= rtc_ctrl_pkg::DIV_ZERO;
        end else if (divWrap) begin
            secCount_reg <= (secCount_reg == rtc_ctrl_pkg::ADJ_PERIOD_LAST) ? 6'h00
                                                                          : secCount_reg + 6'h01;
            if (secCount_reg == rtc_ctrl_pkg::ADJ_PERIOD_LAST && adjust_reg[5:0] > 6'h01) begin
                // sign clear runs fast by skipping counts, set preloads zero minus the step so the next wrap comes after only that many counts
                div_reg <= adjust_reg[rtc_ctrl_pkg::ADJ_SIGN]
                         ? rtc_ctrl_pkg::DIV_ZERO - rtc_ctrl_pkg::DIV_W'(adjust_reg[5:0]
                           * rtc_ctrl_pkg::ADJ_STEP_COUNTS)
                         : rtc_ctrl_pkg::DIV_W'(adjust_reg[5:0] * rtc_ctrl_pkg::ADJ_STEP_COUNTS);
            end else begin
                div_reg <= rtc_ctrl_pkg::DIV_ZERO;
            end
        end else if (oscRise) begin
            div_reg <= div_reg + 15'h0001;
        end
    end

    // delay from the pulse falling edge to the seconds increment
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            delay_reg <= '0;
            delayRun_reg <= 1'b0;
            secondTick <= 1'b0;
        end else begin
            secondTick <= delayRun_reg && delay_reg == rtc_ctrl_pkg::DELAY_W'(1);
            if (wrSeconds) begin
                delayRun_reg <= 1'b0;
            end else if (divWrap) begin
                delay_reg <= rtc_ctrl_pkg::DELAY_W'(rtc_ctrl_pkg::TICK_DELAY_CYCLES);
                delayRun_reg <= 1'b1;
            end else if (delayRun_reg) begin
                delay_reg <= delay_reg - rtc_ctrl_pkg::DELAY_W'(1);
                delayRun_reg <= delay_reg != rtc_ctrl_pkg::DELAY_W'(1);
            end
        end
    end

    // control register 1 and adjustment, held clear while power-up flag is set
    always_ff @(posedge clock) begin
        if (!reset_n || powerUp_reg) begin
            ctrl1_reg <= rtc_ctrl_pkg::CTRL1_RESET;
            adjust_reg <= rtc_ctrl_pkg::ADJUST_RESET;
        end else begin
            if (wrCtrl1) begin
                ctrl1_reg <= regWriteData;
            end
            if (wrAdjust) begin
                adjust_reg <= regWriteData[6:0];
            end
        end
    end

    // control register 2 fields; hardware set wins over software clear
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            powerUp_reg <= 1'b1;
            oscRun_reg <= 1'b0;
            {vthresh_reg, lowVolt_reg, clkDisA_reg} <= 3'h0;
            {periodic_reg, weekly_reg, daily_reg} <= 3'h0;
        end else begin
            if (oscHalted) begin
                oscRun_reg <= 1'b0;
            end else if (wrCtrl2) begin
                oscRun_reg <= regWriteData[rtc_ctrl_pkg::C2_OSC_RUN];
            end
            if (wrCtrl2 && !regWriteData[rtc_ctrl_pkg::C2_POWER_UP]) begin
                powerUp_reg <= 1'b0;
            end
            if (powerUp_reg) begin
                {vthresh_reg, lowVolt_reg, clkDisA_reg} <= 3'h0;
                {periodic_reg, weekly_reg, daily_reg} <= 3'h0;
            end else begin
                if (wrCtrl2) begin
                    vthresh_reg <= regWriteData[rtc_ctrl_pkg::C2_VTHRESH];
                    clkDisA_reg <= regWriteData[rtc_ctrl_pkg::C2_CLK_DIS_A];
                end
                // low supply latches and stops the monitor until cleared
                if (lowLevel_reg) begin
                    lowVolt_reg <= 1'b1;
                end else if (wrCtrl2 && !regWriteData[rtc_ctrl_pkg::C2_LOW_VOLT]) begin
                    lowVolt_reg <= 1'b0;
                end
                // periodic flag follows the output outside level mode
                if (!levelMode) begin
                    periodic_reg <= periodicLow;
                end else if (secondTick && levelEvent) begin
                    periodic_reg <= 1'b1;
                end else if (wrCtrl2 && !regWriteData[rtc_ctrl_pkg::C2_PERIODIC]) begin
                    periodic_reg <= 1'b0;
                end
                // alarm flags read zero while their circuit is disabled
                if (!ctrl1_reg[rtc_ctrl_pkg::C1_WEEKLY_EN]) begin
                    weekly_reg <= 1'b0;
                end else if (weeklyMatch) begin
                    weekly_reg <= 1'b1;
                end else if (wrCtrl2 && !regWriteData[rtc_ctrl_pkg::C2_WEEKLY]) begin
                    weekly_reg <= 1'b0;
                end
                if (!ctrl1_reg[rtc_ctrl_pkg::C1_DAILY_EN]) begin
                    daily_reg <= 1'b0;
                end else if (dailyMatch) begin
                    daily_reg <= 1'b1;
                end else if (wrCtrl2 && !regWriteData[rtc_ctrl_pkg::C2_DAILY]) begin
                    daily_reg <= 1'b0;
                end
            end
        end
    end

    assign ctrl2Value = {vthresh_reg, lowVolt_reg, oscRun_reg, powerUp_reg, clkDisA_reg,
                         periodic_reg, weekly_reg, daily_reg};

    // registered outputs and read data
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            regReadData <= 8'h00;
            hourNext <= 6'h00;
            interrupt_out_n <= 1'b1;
            clk32_out <= 1'b1;
        end else begin
            unique case (regAddr)
                rtc_ctrl_pkg::ADDR_CTRL1: regReadData <= ctrl1_reg;
                rtc_ctrl_pkg::ADDR_CTRL2: regReadData <= ctrl2Value;
                rtc_ctrl_pkg::ADDR_OSC_ADJUST: regReadData <= {1'b0, adjust_reg};
                default: regReadData <= 8'h00;
            endcase
            hourNext <= hourAfter(hourNow, ctrl1_reg[rtc_ctrl_pkg::C1_HOUR24]);
            interrupt_out_n <= !(periodicLow || weekly_reg || daily_reg);
            clk32_out <= (ctrl1_reg[rtc_ctrl_pkg::C1_CLK_DIS_B] && clkDisA_reg) || oscLevel_reg;
        end
    end

    assign hour24Mode = ctrl1_reg[rtc_ctrl_pkg::C1_HOUR24];
    assign weeklyAlarmEnable = ctrl1_reg[rtc_ctrl_pkg::C1_WEEKLY_EN];
    assign dailyAlarmEnable = ctrl1_reg[rtc_ctrl_pkg::C1_DAILY_EN];
    assign testMode = ctrl1_reg[rtc_ctrl_pkg::C1_TEST];
    assign voltageThresholdSelect = vthresh_reg;
    assign supplyMonitorEnable = !lowVolt_reg;

    // assertions
    sequence secWriteSeq;
        wrSeconds && pulseMode ##1 !wrCtrl1;
    endsequence
    clk_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
        (ctrl1_reg[rtc_ctrl_pkg::C1_CLK_DIS_B] && clkDisA_reg) |=> clk32_out)
        else $error("clock output not held high when disabled");
    pon_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
        powerUp_reg |=> ctrl1_reg == 8'h00 && adjust_reg == 7'h00 && !clkDisA_reg)
        else $error("control bits not cleared under power-up flag");
    fixed_low_a: assert property (@(posedge clock) disable iff (!reset_n)
        periodicSel == rtc_ctrl_pkg::PER_LOW |=> !interrupt_out_n)
        else $error("fixed low selection did not drive output low");
    off_mode_a: assert property (@(posedge clock) disable iff (!reset_n)
        periodicSel == rtc_ctrl_pkg::PER_OFF && !weekly_reg && !daily_reg |=> interrupt_out_n)
        else $error("off selection drove output low");
    sec_write_a: assert property (@(posedge clock) disable iff (!reset_n)
        secWriteSeq |=> !interrupt_out_n)
        else $error("seconds write did not drive pulse output low");
    level_fall_a: assert property (@(posedge clock) disable iff (!reset_n)
        secondTick && levelMode && levelEvent && !powerUp_reg && !wrCtrl1
        |=> periodic_reg ##1 !interrupt_out_n)
        else $error("level output did not fall with second increment");
    tick_delay_a: assert property (@(posedge clock) disable iff (!reset_n)
        divWrap && !wrSeconds |=> delay_reg == rtc_ctrl_pkg::DELAY_W'(1840) && !secondTick)
        else $error("seconds increment delay not started");
    alarm_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
        !ctrl1_reg[rtc_ctrl_pkg::C1_WEEKLY_EN] |=> !weekly_reg)
        else $error("weekly flag set while alarm disabled");
    hour_wrap_a: assert property (@(posedge clock) disable iff (!reset_n)
        !hour24Mode && hourNow == 6'h11 |=> hourNext == 6'h32)
        else $error("AM11 did not advance to PM12");
    flag_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
        levelMode && !powerUp_reg && wrCtrl2 && !regWriteData[rtc_ctrl_pkg::C2_PERIODIC]
        && !secondTick
        |=> !periodic_reg)
        else $error("periodic flag not cleared by zero write");
endmodule

// file: sim/host_model.sv
// host cpu model on the register port of the control block
// assumes the bench calls its tasks; it drives only on falling edges
`timescale 1ns/1ps
module host_model (
    input wire logic clock,
    input wire logic [7:0] regReadData,
    output logic [3:0] regAddr,
    output logic regWrite,
    output logic [7:0] regWriteData
);
    // idle port: no strobe, data line not left at a stale value
    initial begin
        regAddr = 4'h0;
        regWrite = 1'b0;
        regWriteData = 8'h5A;
    end
    // single-byte write: strobe for one cycle, then data driven to its complement
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clock);
        regAddr = a;
        regWrite = 1'b1;
        regWriteData = d;
        @(negedge clock);
        regWrite = 1'b0;
        regWriteData = ~d;
    endtask
    // read: address held, registered answer taken a cycle later
    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        @(negedge clock);
        regAddr = a;
        @(negedge clock);
        q = regReadData;
    endtask
    // first control register write; the factory test bit is kept clear
    task automatic ctl1(input logic [7:0] d);
        wr(rtc_ctrl_pkg::ADDR_CTRL1, d & ~(8'h01 << rtc_ctrl_pkg::C1_TEST));
    endtask
endmodule

// file: sim/rtc_control_interrupt_config_tb_top.sv
// self-checking bench for the control-register block
// assumes the host model on the register port and a fast oscillator pin
`timescale 1ns/1ps
module rtc_control_interrupt_config_tb_top;
    logic clock, reset_n, oscPin, weeklyMatch, dailyMatch, minuteCarry;
    logic lowSupplyPin, oscHalted, hourCarry, monthCarry;
    logic [5:0] hourNow;
    wire logic [3:0] regAddr;
    wire logic regWrite, secondTick, hour24Mode, weeklyAlarmEnable, dailyAlarmEnable;
    wire logic testMode, voltageThresholdSelect, supplyMonitorEnable;
    wire logic interrupt_out_n, clk32_out;
    wire logic [7:0] regWriteData, regReadData;
    wire logic [5:0] hourNext;
    int bad_count, checks, cyc, t0, e;
    logic [7:0] q;
    // hour steps: three in 12-hour form, three in 24-hour form
    logic [5:0] hn [6] = '{6'h11, 6'h31, 6'h12, 6'h23, 6'h11, 6'h19};
    logic [5:0] hx [6] = '{6'h32, 6'h12, 6'h01, 6'h00, 6'h12, 6'h20};

    rtc_control dut_u (.clock(clock), .reset_n(reset_n), .regAddr(regAddr),
        .regWrite(regWrite), .regWriteData(regWriteData), .regReadData(regReadData),
        .oscPin(oscPin), .lowSupplyPin(lowSupplyPin), .oscHalted(oscHalted),
        .weeklyMatch(weeklyMatch), .dailyMatch(dailyMatch), .minuteCarry(minuteCarry),
        .hourCarry(hourCarry), .monthCarry(monthCarry), .hourNow(hourNow), .hourNext(hourNext),
        .secondTick(secondTick), .hour24Mode(hour24Mode),
        .weeklyAlarmEnable(weeklyAlarmEnable), .dailyAlarmEnable(dailyAlarmEnable),
        .testMode(testMode), .voltageThresholdSelect(voltageThresholdSelect),
        .supplyMonitorEnable(supplyMonitorEnable), .interrupt_out_n(interrupt_out_n),
        .clk32_out(clk32_out));
    host_model host_u (.clock(clock), .regReadData(regReadData), .regAddr(regAddr),
        .regWrite(regWrite), .regWriteData(regWriteData));

    // 50 ns system clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // cycle count and an oscillator level that flips every other cycle;
    // each level must stand two samples for the pin synchroniser to accept it
    always @(posedge clock) cyc <= cyc + 1;
    always @(negedge clock) begin
        if (cyc[0]) begin
            oscPin <= ~oscPin;
        end
    end
    // verdict and end of run
    task automatic conclude();
        $display("bad_count=%0d checks=%0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // byte comparison
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // register read under a mask
    task automatic rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x);
        host_u.rd(a, q);
        cmp(q & m, x);
    endtask
    // interrupt level reached within a bounded number of cycles
    task automatic waitint(input logic v, input int n);
        int k;
        k = 0;
        while (interrupt_out_n !== v && k < n) begin
            @(negedge clock);
            k++;
        end
        cmp({7'h0, interrupt_out_n}, {7'h0, v});
    endtask
    // count clock-output changes over 20 cycles
    task automatic edges();
        logic p;
        repeat (2) @(negedge clock);
        p = clk32_out;
        e = 0;
        repeat (20) begin
            @(negedge clock);
            if (clk32_out !== p) e++;
            p = clk32_out;
        end
    endtask
    // one-cycle alarm match pulse
    task automatic match(input logic w);
        @(negedge clock);
        if (w) weeklyMatch = 1'b1;
        else dailyMatch = 1'b1;
        @(negedge clock);
        weeklyMatch = 1'b0;
        dailyMatch = 1'b0;
    endtask
    // wait until a cycle count after the seconds write
    task automatic till(input int c);
        while (cyc - t0 < c) @(negedge clock);
    endtask
    // watchdog: one divider second is 131072 cycles, plus tick delay and margin
    initial begin
        repeat (140000) @(posedge clock);
        bad_count++;
        conclude();
    end
    // main sequence
    initial begin
        reset_n = 1'b0;
        {weeklyMatch, dailyMatch, minuteCarry, oscPin} = 4'h0;
        {lowSupplyPin, oscHalted, hourCarry, monthCarry} = 4'h0;
        hourNow = 6'h00;
        {cyc, bad_count, checks} = '0;
        repeat (10) @(negedge clock);
        reset_n = 1'b1;
        rdc(rtc_ctrl_pkg::ADDR_CTRL2, 8'hDF, 8'h10);
        rdc(rtc_ctrl_pkg::ADDR_CTRL1, 8'hFF, 8'h00);
        cmp({7'h0, interrupt_out_n}, 8'h01);
        edges();
        cmp({7'h0, e > 5}, 8'h01);
        // control register 1 and adjustment writes are ignored while the power-up flag stands
        host_u.wr(rtc_ctrl_pkg::ADDR_CTRL1, 8'hFF);
        host_u.wr(rtc_ctrl_pkg::ADDR_OSC_ADJUST, 8'h3F);
        rdc(rtc_ctrl_pkg::ADDR_CTRL1, 8'hFF, 8'h00);
        rdc(rtc_ctrl_pkg::ADDR_OSC_ADJUST, 8'hFF, 8'h00);
        host_u.wr(rtc_ctrl_pkg::ADDR_CTRL2, 8'h00);
        rdc(rtc_ctrl_pkg::ADDR_CTRL2, 8'hDB, 8'h00);
        // hour format chosen before any hour value is applied
        for (int i = 0; i < 6; i++) begin
            if (i % 3 == 0) host_u.ctl1(i == 3 ? 8'h20 : 8'h00);
            @(negedge clock);
            hourNow = hn[i];
            @(negedge clock);
            cmp({2'b00, hourNext}, {2'b00, hx[i]});
            cmp({7'h0, hour24Mode}, {7'h0, i > 2});
        end
        // every periodic selection code read back
        for (int c = 0; c < 8; c++) begin
            host_u.ctl1({5'h00, c[2:0]});
            rdc(rtc_ctrl_pkg::ADDR_CTRL1, 8'h07, {5'h00, c[2:0]});
            if (c < 2) cmp({7'h0, interrupt_out_n}, {7'h0, c == 0});
        end
        // alarms: weekly ignored when disabled, flagged and clearable when enabled; daily flagged when enabled
        host_u.ctl1(8'h00);
        match(1'b1);
        rdc(rtc_ctrl_pkg::ADDR_CTRL2, 8'h03, 8'h00);
        host_u.ctl1(8'hC0);
        cmp({6'h0, weeklyAlarmEnable, dailyAlarmEnable}, 8'h03);
        match(1'b1);
        waitint(1'b0, 4);
        rdc(rtc_ctrl_pkg::ADDR_CTRL2, 8'h03, 8'h02);
        host_u.wr(rtc_ctrl_pkg::ADDR_CTRL2, 8'h00);
        waitint(1'b1, 4);
        match(1'b0);
        rdc(rtc_ctrl_pkg::ADDR_CTRL2, 8'h03, 8'h01);
        host_u.wr(rtc_ctrl_pkg::ADDR_CTRL2, 8'h00);
        // clock output stops only with both disables set
        host_u.ctl1(8'h10);
        edges();
        cmp({7'h0, e > 5}, 8'h01);
        host_u.wr(rtc_ctrl_pkg::ADDR_CTRL2, 8'h08);
        edges();
        cmp({e[6:0], clk32_out}, 8'h01);
        host_u.ctl1(8'h00);
        edges();
        cmp({7'h0, e > 5}, 8'h01);
        host_u.wr(rtc_ctrl_pkg::ADDR_CTRL2, 8'h80);
        cmp({7'h0, voltageThresholdSelect}, 8'h01);
        rdc(rtc_ctrl_pkg::ADDR_CTRL2, 8'h80, 8'h80);
        host_u.wr(rtc_ctrl_pkg::ADDR_CTRL2, 8'h00);
        // a low supply latches its flag and stops the monitor until a zero write
        lowSupplyPin = 1'b1;
        repeat (6) @(negedge clock);
        lowSupplyPin = 1'b0;
        cmp({7'h0, supplyMonitorEnable}, 8'h00);
        repeat (6) @(negedge clock);
        rdc(rtc_ctrl_pkg::ADDR_CTRL2, 8'h40, 8'h40);
        host_u.wr(rtc_ctrl_pkg::ADDR_CTRL2, 8'h00);
        rdc(rtc_ctrl_pkg::ADDR_CTRL2, 8'h40, 8'h00);
        cmp({7'h0, supplyMonitorEnable}, 8'h01);
        // oscillator-running flag written high, then dropped by a halt
        host_u.wr(rtc_ctrl_pkg::ADDR_CTRL2, 8'h20);
        rdc(rtc_ctrl_pkg::ADDR_CTRL2, 8'h20, 8'h20);
        oscHalted = 1'b1;
        @(negedge clock);
        oscHalted = 1'b0;
        rdc(rtc_ctrl_pkg::ADDR_CTRL2, 8'h20, 8'h00);
        // pulse modes timed from a seconds write; off selection stands high first
        waitint(1'b1, 4);
        host_u.ctl1(8'h02);
        host_u.wr(rtc_ctrl_pkg::ADDR_SECONDS, 8'h00);
        t0 = cyc;
        waitint(1'b0, 4);
        till(32768 - 128);
        cmp({7'h0, interrupt_out_n}, 8'h00);
        till(32768 + 256);
        cmp({7'h0, interrupt_out_n}, 8'h01);
        host_u.ctl1(8'h03);
        till(65536 - 128);
        cmp({7'h0, interrupt_out_n}, 8'h00);
        till(65536 + 256);
        cmp({7'h0, interrupt_out_n}, 8'h01);
        // minute event in level mode at the next seconds increment
        minuteCarry = 1'b1;
        host_u.ctl1(8'h05);
        e = 0;
        while (secondTick !== 1'b1 && e < 70000) begin
            @(negedge clock);
            e++;
        end
        cmp({7'h0, (cyc - t0) inside {[132905:132916]}}, 8'h01);
        waitint(1'b0, 4);
        rdc(rtc_ctrl_pkg::ADDR_CTRL2, 8'h04, 8'h04);
        host_u.wr(rtc_ctrl_pkg::ADDR_CTRL2, 8'h00);
        waitint(1'b1, 4);
        conclude();
    end
endmodule
